// >>> inc/afsc_pkg.sv
// package of constants for the converter fifo status/control block
package afsc_pkg;
  localparam int DATA_W = 12;
  localparam int WORD_W = 13;
  localparam int FIFO_DEPTH = 8;
  localparam int CNT_W = 4;
  // fifo word loaded at reset: 1000 0000 0000, range bit clear
  localparam logic [12:0] FIFO_RESET_WORD = 13'h0800;
  // status/control field positions
  localparam int BIT_ALMOST_FULL = 11;
  localparam int BIT_THRESH_HI = 10;
  localparam int BIT_THRESH_LO = 8;
  localparam int BIT_AF_DISABLE = 7;
  localparam int BIT_OVERRUN_RST = 6;
  localparam int BIT_RANGE_BLOCK = 5;
  localparam int BIT_EMPTY = 4;
  localparam int BIT_SAMPLE_OOR = 3;
  localparam int BIT_COUNT_HI = 2;
  // control reset values
  localparam logic [2:0] THRESH_RESET = 3'h0;
  localparam logic AF_DISABLE_RESET = 1'b0;
  localparam logic OUT_BLOCK_RESET = 1'b0;
  // conversion timing
  localparam int CLK_MHZ = 200;
  localparam int CONV_TIME_NS = 7000;
  localparam int CONV_CYCLES = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int HOLD_TIME_NS = 2000;
  localparam int HOLD_CYCLES = (HOLD_TIME_NS * CLK_MHZ) / 1000;
  localparam int TIMER_W = 11;
endpackage

// >>> rtl/afsc_top.sv
// converter fifo, status/control register and almost-full logic
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/100ps

// ---------------------------------------------------------------
// result fifo with valid/ready on both sides
// ---------------------------------------------------------------
module afsc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic ce,
  input wire logic flush,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  output logic [$clog2(DEPTH):0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] rd_ptr;
  logic [AW-1:0] wr_ptr;
  logic [AW:0] fill;
  logic [AW-1:0] last_rd;
  wire do_push = in_valid && in_ready;
  wire do_pop = out_valid && out_ready;
  // a full fifo still takes a word when a read frees a slot that cycle
  assign in_ready = (fill != (AW+1)'(DEPTH)) || out_ready;
  assign out_valid = fill != '0;
  // an empty fifo keeps showing the last word read
  assign out_data = out_valid ? mem[rd_ptr] : mem[last_rd];
  assign count = fill;

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_ptr <= '0;
      wr_ptr <= '0;
      fill <= '0;
      last_rd <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        rd_ptr <= '0;
        wr_ptr <= '0;
        fill <= '0;
        last_rd <= '0;
      end
      else
      begin
        if (do_push)
          wr_ptr <= wr_ptr + 1'b1;
        if (do_pop)
        begin
          last_rd <= rd_ptr;
          rd_ptr <= rd_ptr + 1'b1;
        end
        fill <= fill + (AW+1)'(do_push) - (AW+1)'(do_pop);
      end
    end
  end

  genvar i;
  generate
    for (i = 0; i < DEPTH; i++)
    begin : g_word
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          mem[i] <= INIT;
        else if (ce && flush)
          mem[i] <= INIT;
        else if (ce && do_push && wr_ptr == AW'(i))
          mem[i] <= in_data;
      end
    end
  endgenerate
endmodule

// ---------------------------------------------------------------
// top: conversion sequencing and register interface
// ---------------------------------------------------------------
module afsc_top #(
  parameter int DEPTH = afsc_pkg::FIFO_DEPTH,
  parameter int CONV_CYCLES = afsc_pkg::CONV_CYCLES,
  parameter int HOLD_CYCLES = afsc_pkg::HOLD_CYCLES
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic CONVERSION_START_STROBE,
  input wire logic [11:0] RESULT_IN,
  input wire logic RESULT_OOR,
  input wire logic REGISTER_SELECT,
  input wire logic [2:0] ADDR,
  input wire logic [11:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [11:0] RDATA,
  output logic DATA_LINES_OE_N,
  output logic HOLD,
  output logic BUSY_N,
  output logic ALMOST_FULL_N
);
  typedef enum logic [2:0] {
    AFSC_IDLE = 3'b001,
    AFSC_HOLD = 3'b010,
    AFSC_CONV = 3'b100
  } afsc_state_t;

  afsc_state_t state;
  afsc_state_t next_state;
  logic [afsc_pkg::TIMER_W-1:0] timer;
  logic start_meta, start_sync, start_prev;
  logic [2:0] thresh;
  logic af_disable;
  logic output_block_during_busy;
  logic overrun;
  logic range_seen;
  logic [12:0] fifo_out;
  logic fifo_valid;
  logic fifo_in_ready;
  logic [3:0] fifo_count;
  logic soft_reset;

  // start is asynchronous to the clock and the bus: two flops then edge
  wire start_rise = start_sync && !start_prev;
  wire conv_done = (state == AFSC_CONV) && (timer == '0);
  wire push = conv_done && fifo_in_ready;
  wire reg_wr = WR && REGISTER_SELECT;
  wire data_rd = RD && !REGISTER_SELECT;
  wire fifo_empty = !fifo_valid;
  // ---------------------------------------------------------------
  // almost-full evaluation
  // ---------------------------------------------------------------
  // a register write judges the flag with the values being written, so a
  // new threshold or disable acts at once instead of at the next conversion
  wire [2:0] thresh_eff = reg_wr ?
    WDATA[afsc_pkg::BIT_THRESH_HI:afsc_pkg::BIT_THRESH_LO] : thresh;
  wire af_dis_eff = reg_wr ? WDATA[afsc_pkg::BIT_AF_DISABLE] : af_disable;
  // threshold code n fires at n+1 words, giving 1 to 8
  wire [3:0] thresh_words = {1'b0, thresh_eff} + 4'h1;
  wire [3:0] count_after = fifo_count + 4'(push) - 4'(data_rd && fifo_valid);
  wire at_thresh = count_after >= thresh_words;
  wire next_af_n = af_dis_eff || !at_thresh;
  wire [2:0] word_count = (fifo_count == 4'h0) ? 3'h0 : 3'(fifo_count - 4'h1);
  wire [11:0] status_word = {ALMOST_FULL_N, thresh, af_disable, overrun,
    range_seen, fifo_empty, fifo_out[12] && fifo_valid, word_count};
  wire [11:0] next_rdata = REGISTER_SELECT ? status_word : fifo_out[11:0];
  wire bus_block = !output_block_during_busy && !BUSY_N;

  // ---------------------------------------------------------------
  // state decode
  // ---------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      AFSC_IDLE: if (start_rise) next_state = AFSC_HOLD;
      AFSC_HOLD: if (timer == '0) next_state = AFSC_CONV;
      AFSC_CONV: if (timer == '0) next_state = AFSC_IDLE;
      default: next_state = AFSC_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // conversion sequencing
  // ---------------------------------------------------------------
  // single clock domain with counted phases, so clock duty is irrelevant
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      start_meta <= 1'b0;
      start_sync <= 1'b0;
      start_prev <= 1'b0;
      state <= AFSC_IDLE;
      timer <= '0;
      HOLD <= 1'b0;
      BUSY_N <= 1'b1;
    end
    else if (CE)
    begin
      start_meta <= CONVERSION_START_STROBE;
      start_sync <= start_meta;
      start_prev <= start_sync;
      state <= next_state;
      if (state == AFSC_IDLE && start_rise)
        timer <= afsc_pkg::TIMER_W'(HOLD_CYCLES - 1);
      else if (state == AFSC_HOLD && timer == '0)
        timer <= afsc_pkg::TIMER_W'(CONV_CYCLES - HOLD_CYCLES - 1);
      else if (timer != '0)
        timer <= timer - 1'b1;
      HOLD <= (next_state != AFSC_IDLE);
      BUSY_N <= (next_state != AFSC_HOLD);
    end
  end

  // ---------------------------------------------------------------
  // status/control register
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      thresh <= afsc_pkg::THRESH_RESET;
      af_disable <= afsc_pkg::AF_DISABLE_RESET;
      output_block_during_busy <= afsc_pkg::OUT_BLOCK_RESET;
      overrun <= 1'b0;
      range_seen <= 1'b0;
      soft_reset <= 1'b0;
      ALMOST_FULL_N <= 1'b1;
      RDATA <= '0;
      DATA_LINES_OE_N <= 1'b1;
    end
    else if (CE)
    begin
      soft_reset <= reg_wr && WDATA[afsc_pkg::BIT_OVERRUN_RST];
      if (soft_reset)
      begin
        thresh <= afsc_pkg::THRESH_RESET;
        af_disable <= afsc_pkg::AF_DISABLE_RESET;
        output_block_during_busy <= afsc_pkg::OUT_BLOCK_RESET;
        overrun <= 1'b0;
        range_seen <= 1'b0;
        ALMOST_FULL_N <= 1'b1;
      end
      else
      begin
        if (reg_wr)
        begin
          thresh <= WDATA[afsc_pkg::BIT_THRESH_HI:afsc_pkg::BIT_THRESH_LO];
          af_disable <= WDATA[afsc_pkg::BIT_AF_DISABLE];
          output_block_during_busy <= WDATA[afsc_pkg::BIT_RANGE_BLOCK];
        end
        // sets win over nothing else clearing them but reset
        if (conv_done && !fifo_in_ready)
          overrun <= 1'b1;
        if (push && RESULT_OOR)
          range_seen <= 1'b1;
        // refresh at conversion end, release on data read, honour disable
        if (conv_done || data_rd || reg_wr)
          ALMOST_FULL_N <= next_af_n;
        else if (af_disable)
          ALMOST_FULL_N <= 1'b1;
      end
      if (RD)
        RDATA <= bus_block ? 12'h000 : next_rdata;
      DATA_LINES_OE_N <= !(RD && !bus_block);
    end
  end

  // ---------------------------------------------------------------
  // result fifo
  // ---------------------------------------------------------------
  // the soft reset flushes it the same way as the reset pin
  afsc_fifo #(
    .WIDTH(afsc_pkg::WORD_W),
    .DEPTH(DEPTH),
    .INIT(afsc_pkg::FIFO_RESET_WORD)
  ) u_fifo (
    .clk(REF_CLK),
    .arst_n(ARST_N),
    .ce(CE),
    .flush(soft_reset),
    .in_valid(conv_done),
    .in_ready(fifo_in_ready),
    .in_data({RESULT_OOR, RESULT_IN}),
    .out_valid(fifo_valid),
    .out_ready(data_rd),
    .out_data(fifo_out),
    .count(fifo_count)
  );
endmodule

// >>> verif/afsc_chk.sv
// assertion checker for the converter fifo status/control block
`timescale 1ns/100ps
// --
// checker
// --
module afsc_chk #(
  parameter int HOLD_CYCLES = 5,
  parameter int CONV_CYCLES = 20
) (
  input wire logic REF_CLK,
  input wire logic ARST_N,
  input wire logic CONVERSION_START_STROBE,
  input wire logic WR,
  input wire logic RD,
  input wire logic DATA_LINES_OE_N,
  input wire logic HOLD,
  input wire logic BUSY_N,
  input wire logic ALMOST_FULL_N
);
  localparam int CMIN = CONV_CYCLES - 2;
  localparam int CMAX = CONV_CYCLES + 2;
  logic [11:0] blen;
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!ARST_N);
  always_ff @(posedge REF_CLK or negedge ARST_N)
    if (!ARST_N)
      blen <= 12'h000;
    else
      blen <= BUSY_N ? 12'h000 : blen + 12'h001;
  sequence conv_go;
    $rose(HOLD);
  endsequence
  sequence conv_done;
    $fell(HOLD);
  endsequence
  rst_vals_a: assert property (
    $rose(ARST_N) |-> ALMOST_FULL_N && BUSY_N && !HOLD && DATA_LINES_OE_N)
    else $error("outputs not at reset values");
  start_hold_a: assert property (
    $rose(CONVERSION_START_STROBE) && !HOLD |-> ##[1:5] HOLD)
    else $error("start edge did not begin hold");
  busy_len_a: assert property (
    $rose(BUSY_N) |-> blen == HOLD_CYCLES)
    else $error("busy low time wrong");
  conv_len_a: assert property (
    conv_go |-> ##[CMIN:CMAX] conv_done)
    else $error("conversion length wrong");
  busy_hold_a: assert property (
    !BUSY_N |-> HOLD)
    else $error("busy low outside conversion");
  oe_cause_a: assert property (
    !DATA_LINES_OE_N |-> $past(RD))
    else $error("bus driven without read");
  af_fall_a: assert property (
    $fell(ALMOST_FULL_N) |-> $past(HOLD) || $past(HOLD, 2)
      || $past(HOLD, 3) || $past(WR) || $past(WR, 2))
    else $error("almost full set without cause");
  af_rise_a: assert property (
    $rose(ALMOST_FULL_N) |-> $past(RD) || $past(RD, 2)
      || $past(WR) || $past(WR, 2))
    else $error("almost full released without cause");
endmodule
bind afsc_top afsc_chk #(
  .HOLD_CYCLES(HOLD_CYCLES),
  .CONV_CYCLES(CONV_CYCLES)
) u_chk (
  .REF_CLK(REF_CLK), .ARST_N(ARST_N), .WR(WR), .RD(RD),
  .CONVERSION_START_STROBE(CONVERSION_START_STROBE),
  .DATA_LINES_OE_N(DATA_LINES_OE_N), .HOLD(HOLD), .BUSY_N(BUSY_N),
  .ALMOST_FULL_N(ALMOST_FULL_N));

// >>> verif/afsc_src_model.sv
// sample source model standing in for the converter core
`timescale 1ns/100ps
// --
// source
// --
module afsc_src_model (
  input wire logic clk,
  input wire logic hold,
  input wire logic [12:0] new_sample,
  output logic [11:0] result,
  output logic oor
);
  logic [12:0] smp;
  logic hold_q = 1'b0;
  // inverse outside a conversion and the cycle after it, so a sample later than that never looks right
  assign {oor, result} = (hold || hold_q) ? smp : ~smp;
  always_ff @(posedge clk)
  begin
    if (hold && !hold_q)
      smp <= new_sample;
    hold_q <= hold;
  end
endmodule

// >>> verif/tb_top.sv
// self-checking testbench for the converter fifo status/control block
`timescale 1ns/100ps
// --
// bench
// --
module tb_top;
  logic REF_CLK = 1'b0;
  logic ARST_N = 1'b0;
  logic CONVERSION_START_STROBE = 1'b0;
  logic REGISTER_SELECT = 1'b0;
  logic [11:0] WDATA = 12'h000;
  logic WR = 1'b0;
  logic RD = 1'b0;
  logic pend = 1'b0;
  logic [11:0] RDATA, RESULT_IN;
  logic DATA_LINES_OE_N, HOLD, BUSY_N, ALMOST_FULL_N, RESULT_OOR;
  logic [12:0] smp = 13'h0000;
  logic [24:0] rq[$];
  logic blk_exp = 1'b0;
  logic [12:0] dq[$];
  int error_cnt = 0;
  int compares = 0;
  int seed = 19224;
  always #2.5 REF_CLK = ~REF_CLK;
  // short counts keep the run small
  afsc_top #(.CONV_CYCLES(20), .HOLD_CYCLES(5)) u_dut (
    .REF_CLK(REF_CLK), .ARST_N(ARST_N), .CE(1'b1),
    .CONVERSION_START_STROBE(CONVERSION_START_STROBE),
    .RESULT_IN(RESULT_IN), .RESULT_OOR(RESULT_OOR),
    .REGISTER_SELECT(REGISTER_SELECT), .ADDR(3'h0), .WDATA(WDATA),
    .WR(WR), .RD(RD), .RDATA(RDATA), .DATA_LINES_OE_N(DATA_LINES_OE_N),
    .HOLD(HOLD), .BUSY_N(BUSY_N), .ALMOST_FULL_N(ALMOST_FULL_N));
  afsc_src_model u_src (.clk(REF_CLK), .hold(HOLD), .new_sample(smp),
    .result(RESULT_IN), .oor(RESULT_OOR));
  task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
    compares++;
    if (g !== e)
    begin
      error_cnt++;
      $display("ERROR %0s expected %h seen %h", nm, e, g);
    end
  endtask
  task wr(input logic [11:0] d);
    @(posedge REF_CLK);
    REGISTER_SELECT <= 1'b1;
    WDATA <= d;
    WR <= 1'b1;
    @(posedge REF_CLK);
    WR <= 1'b0;
  endtask
  task rd(input logic rs, input logic [11:0] e, input logic [11:0] m);
    @(posedge REF_CLK);
    REGISTER_SELECT <= rs;
    RD <= 1'b1;
    rq.push_back({blk_exp, m, e});
    @(posedge REF_CLK);
    RD <= 1'b0;
  endtask
  task conv(input logic blk);
    logic [12:0] v;
    v = 13'($random(seed));
    dq.push_back(v);
    @(posedge REF_CLK);
    smp <= v;
    CONVERSION_START_STROBE <= 1'b1;
    for (int i = 0; i < 9 && HOLD !== 1'b1; i++)
      @(negedge REF_CLK);
    if (blk)
    begin
      blk_exp = 1'b1;
      rd(1'b1, 12'h000, 12'hfff);
      blk_exp = 1'b0;
      @(negedge REF_CLK);
      chk("oe_n", 12'h001, {11'h0, DATA_LINES_OE_N});
    end
    @(posedge REF_CLK);
    CONVERSION_START_STROBE <= 1'b0;
    for (int i = 0; i < 40 && HOLD !== 1'b0; i++)
      @(negedge REF_CLK);
    repeat (3) @(negedge REF_CLK);
  endtask
  task tally_and_finish;
    $display("compares %0d error_cnt %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // read data are driven onto the bus (DATA_LINES_OE_N low) only in the cycle after the strobe
  always @(posedge REF_CLK)
    pend <= RD;
  always @(negedge REF_CLK)
    if (pend === 1'b1 && rq.size() > 0)
    begin
      chk("rdata", rq[0][11:0] & rq[0][23:12], RDATA & rq[0][23:12]);
      chk("oe_n", {11'h0, rq[0][24]}, {11'h0, DATA_LINES_OE_N});
      void'(rq.pop_front());
    end
  initial
  begin
    #100000;
    error_cnt++;
    tally_and_finish;
  end
  initial
  begin
    logic [12:0] v;
    logic rs_exp;
    repeat (4) @(posedge REF_CLK);
    ARST_N <= 1'b1;
    rd(1'b1, 12'h810, 12'hfff);
    rd(1'b0, 12'h800, 12'hfff);
    $display("test reset done");
    for (int c = 0; c < 8; c++)
    begin
      wr(12'h040);
      wr({1'b0, c[2:0], 8'h20});
      for (int k = 0; k <= c; k++)
      begin
        conv(1'b0);
        chk("af_n", {11'h0, k != c}, {11'h0, ALMOST_FULL_N});
      end
      rs_exp = 1'b0;
      for (int i = 0; i < dq.size(); i++)
        rs_exp = rs_exp | dq[i][12];
      repeat (2) rd(1'b1, {1'b0, c[2:0], 2'b00, rs_exp, 1'b0, dq[0][12],
        c[2:0]}, 12'hfff);
      while (dq.size() > 0)
      begin
        v = dq.pop_front();
        rd(1'b0, v[11:0], 12'hfff);
      end
      @(negedge REF_CLK);
      chk("af_n", 12'h001, {11'h0, ALMOST_FULL_N});
      rd(1'b1, {1'b1, c[2:0], 2'b00, rs_exp, 1'b1, 4'h0}, 12'hfff);
      $display("test threshold %0d done", c);
    end
    wr(12'h040);
    wr(12'h780);
    repeat (9) conv(1'b0);
    chk("af_n", 12'h001, {11'h0, ALMOST_FULL_N});
    rs_exp = 1'b0;
    for (int i = 0; i < 8; i++)
      rs_exp = rs_exp | dq[i][12];
    rd(1'b1, {6'h3f, rs_exp, 1'b0, dq[0][12], 3'h7}, 12'hfff);
    conv(1'b1);
    for (int k = 0; k < 8; k++)
    begin
      v = dq.pop_front();
      rd(1'b0, v[11:0], 12'hfff);
    end
    dq.delete();
    $display("test overrun done");
    tally_and_finish;
  end
endmodule
